/* File: hw/drp_request_port.sv */
// Request queue, write data buffer and command issue of the DRAM local port.
`timescale 1ns/1ps
`include "drp_cfg.svh"

// ------------------------------------------------------------
// Generic FIFO with registered flags
// ------------------------------------------------------------
module drp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          room_q, room_d, empty_q, empty_d;
  logic          push, pop;
  // Room and empty are registered so the ready output is a flop, not an inverter.
  always_comb begin
    push    = in_valid && room_q;
    pop     = out_ready && !empty_q;
    wr_d    = push ? wr_q + 1'b1 : wr_q;
    rd_d    = pop ? rd_q + 1'b1 : rd_q;
    cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    room_d  = (cnt_d != (AW+1)'(D));
    empty_d = (cnt_d == '0);
  end
  // Pointer and flag registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      room_q  <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      room_q  <= room_d;
      empty_q <= empty_d;
    end
  end
  // Storage has no reset; only words behind valid pointers are ever read.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  assign in_ready  = room_q;
  assign out_valid = !empty_q;
  assign out_data  = mem_q[rd_q];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_full_no_ready: assert property (cnt_q == (AW+1)'(D) |-> !in_ready)
    else $error("FIFO offers ready while holding its full depth");
  a_push_counts: assert property (in_valid && in_ready && !(out_ready && out_valid)
      |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("Accepted entry was not counted");
  c_fifo_full: cover property (cnt_q == (AW+1)'(D));
endmodule

// How it works
// - Write data is twice or four times DQ
// - Broadcast write selects every chip
// - Close-row request issues auto-precharge command
// - Auto-precharge only on the final beat
// - Enter self-refresh when timing allows, then acknowledge
// - Stay in self-refresh while request held
// - Exit on release; drop acknowledge after exit
// - Ready output rises after sequencer calibration done, then stays high
// - Queue requests early; issue only after ready
// - Ready means finished, not calibration passed
// - Accepted when request meets accept-ready high
// - Queue eight requests; drop ready when full
module drp_request_port (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     req_read,
  input  wire logic                     req_write,
  input  wire logic [`DRP_ADDR_W-1:0]   req_addr,
  input  wire logic [`DRP_SIZE_W-1:0]   req_size,
  input  wire logic                     req_bcast,
  input  wire logic                     req_close_row,
  output logic                          req_ready,
  input  wire logic                     wr_valid,
  input  wire logic [`DRP_WDATA_W-1:0]  wr_data,
  input  wire logic [`DRP_BE_W-1:0]     wr_be,
  output logic                          wr_ready,
  input  wire logic                     sr_req,
  output logic                          sr_ack,
  input  wire logic                     phy_cal_done,
  output logic                          init_done,
  output logic                          mem_cmd_valid,
  input  wire logic                     mem_cmd_ready,
  output drp_pkg::drp_cmd_t             mem_cmd,
  output logic [`DRP_CS_W-1:0]          mem_cs,
  output logic [`DRP_ADDR_W-1:0]        mem_addr,
  output logic [`DRP_WDATA_W-1:0]       mem_wdata,
  output logic [`DRP_BE_W-1:0]          mem_be
);
  localparam int EW = `DRP_ENTRY_W;
  localparam int DW = `DRP_WDATA_W + `DRP_BE_W;
  localparam int CW = `DRP_CS_W;
  localparam int AW = `DRP_ADDR_W;
  // ------------------------------------------------------------
  // Request capture and queues
  // ------------------------------------------------------------
  logic          q_in_valid, q_in_ready, q_out_valid, q_pop;
  logic [EW-1:0] q_in, q_out;
  logic          d_in_ready, d_out_valid, d_pop;
  logic [DW-1:0] d_out;
  // The entry takes its kind and flags in the accepting cycle only.
  always_comb begin
    q_in_valid = req_read || req_write;
    q_in       = '0;
    q_in[`DRP_E_WRITE] = req_write;
    q_in[`DRP_E_BCAST] = req_write && req_bcast;
    q_in[`DRP_E_CLOSE] = req_close_row && `DRP_AUTOPCH_EN;
    q_in[`DRP_E_SIZE_LO +: `DRP_SIZE_W] = req_size;
    q_in[`DRP_E_ADDR_LO +: AW] = req_addr;
  end
  // Eight-deep command queue; its ready is the user accept-ready.
  drp_fifo #(.W(EW), .D(`DRP_REQ_DEPTH)) u_req_q (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (q_in_valid),
    .in_data   (q_in),
    .in_ready  (q_in_ready),
    .out_valid (q_out_valid),
    .out_data  (q_out),
    .out_ready (q_pop)
  );
  // Four-word write data buffer; a stalled memory side fills it.
  drp_fifo #(.W(DW), .D(`DRP_DAT_DEPTH)) u_dat_q (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_data   ({wr_be, wr_data}),
    .in_ready  (d_in_ready),
    .out_valid (d_out_valid),
    .out_data  (d_out),
    .out_ready (d_pop)
  );
  assign req_ready = q_in_ready;
  assign wr_ready  = d_in_ready;
  // ------------------------------------------------------------
  // Issue and self-refresh state machine
  // ------------------------------------------------------------
  drp_pkg::drp_state_t st_q, st_d;
  drp_pkg::drp_cmd_t   cmd_q, cmd_d;
  logic                vld_q, vld_d, ack_q, ack_d, init_q, init_d;
  logic                wr_q, wr_d, bc_q, bc_d, cl_q, cl_d;
  logic [`DRP_SIZE_W-1:0] left_q, left_d;
  logic [AW-1:0]       cur_q, cur_d, addr_q, addr_d;
  logic [CW-1:0]       cs_q, cs_d;
  logic [DW-1:0]       dat_q, dat_d;
  logic                fire;
  // Chip select of one address, or every chip for a broadcast write.
  function automatic logic [CW-1:0] chip_sel(input logic [AW-1:0] a, input logic all);
    return all ? {CW{1'b1}} : CW'(1) << a[AW-1 -: $clog2(CW)];
  endfunction
  // Self-refresh is checked only between requests, the earliest legal point.
  always_comb begin
    st_d   = st_q;
    cmd_d  = cmd_q;
    vld_d  = vld_q && !mem_cmd_ready;
    ack_d  = ack_q;
    init_d = init_q || phy_cal_done;
    wr_d   = wr_q;
    bc_d   = bc_q;
    cl_d   = cl_q;
    left_d = left_q;
    cur_d  = cur_q;
    addr_d = addr_q;
    cs_d   = cs_q;
    dat_d  = dat_q;
    q_pop  = 1'b0;
    d_pop  = 1'b0;
    fire   = vld_q && mem_cmd_ready;
    case (st_q)
      drp_pkg::DRP_ST_INIT: begin
        if (init_q) begin
          st_d = drp_pkg::DRP_ST_IDLE;
        end
      end
      drp_pkg::DRP_ST_IDLE: begin
        if (sr_req) begin
          vld_d = 1'b1;
          cmd_d = drp_pkg::DRP_CMD_SRE;
          st_d  = drp_pkg::DRP_ST_SR_IN;
        end else if (q_out_valid) begin
          q_pop  = 1'b1;
          wr_d   = q_out[`DRP_E_WRITE];
          bc_d   = q_out[`DRP_E_BCAST];
          cl_d   = q_out[`DRP_E_CLOSE];
          left_d = q_out[`DRP_E_SIZE_LO +: `DRP_SIZE_W];
          cur_d  = q_out[`DRP_E_ADDR_LO +: AW];
          if (left_d == '0) begin
            left_d = `DRP_SIZE_W'(1);
          end
          st_d   = drp_pkg::DRP_ST_ISSUE;
        end
      end
      drp_pkg::DRP_ST_ISSUE: begin
        if (fire && left_q == `DRP_SIZE_W'(1)) begin
          st_d = drp_pkg::DRP_ST_IDLE;
        end else if (fire) begin
          left_d = left_q - 1'b1;
          cur_d  = cur_q + 1'b1;
        end else if (!vld_q && (!wr_q || d_out_valid)) begin
          vld_d  = 1'b1;
          d_pop  = wr_q;
          dat_d  = wr_q ? d_out : '0;
          addr_d = cur_q;
          cs_d   = chip_sel(cur_q, bc_q);
          if (cl_q && left_q == `DRP_SIZE_W'(1)) begin
            cmd_d = wr_q ? drp_pkg::DRP_CMD_WRA : drp_pkg::DRP_CMD_RDA;
          end else begin
            cmd_d = wr_q ? drp_pkg::DRP_CMD_WR : drp_pkg::DRP_CMD_RD;
          end
        end
      end
      drp_pkg::DRP_ST_SR_IN: begin
        if (fire) begin
          ack_d = 1'b1;
          st_d  = drp_pkg::DRP_ST_SR_HLD;
        end
      end
      drp_pkg::DRP_ST_SR_HLD: begin
        if (!sr_req) begin
          vld_d = 1'b1;
          cmd_d = drp_pkg::DRP_CMD_SRX;
          st_d  = drp_pkg::DRP_ST_SR_OUT;
        end
      end
      drp_pkg::DRP_ST_SR_OUT: begin
        if (fire) begin
          ack_d = 1'b0;
          st_d  = drp_pkg::DRP_ST_IDLE;
        end
      end
      default: begin
        st_d  = drp_pkg::DRP_ST_INIT;
        vld_d = 1'b0;
      end
    endcase
  end
  // State registers; every top output except req_ready and wr_ready is one of these flops.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q   <= drp_pkg::DRP_ST_INIT;
      cmd_q  <= drp_pkg::DRP_CMD_RD;
      vld_q  <= 1'b0;
      ack_q  <= 1'b0;
      init_q <= 1'b0;
      wr_q   <= 1'b0;
      bc_q   <= 1'b0;
      cl_q   <= 1'b0;
      left_q <= '0;
      cur_q  <= '0;
      addr_q <= '0;
      cs_q   <= '0;
      dat_q  <= '0;
    end else begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      vld_q  <= vld_d;
      ack_q  <= ack_d;
      init_q <= init_d;
      wr_q   <= wr_d;
      bc_q   <= bc_d;
      cl_q   <= cl_d;
      left_q <= left_d;
      cur_q  <= cur_d;
      addr_q <= addr_d;
      cs_q   <= cs_d;
      dat_q  <= dat_d;
    end
  end
  assign mem_cmd_valid = vld_q;
  assign mem_cmd       = cmd_q;
  assign mem_cs        = cs_q;
  assign mem_addr      = addr_q;
  assign {mem_be, mem_wdata} = dat_q;
  assign sr_ack        = ack_q;
  assign init_done     = init_q;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_no_issue_early: assert property (mem_cmd_valid |-> init_done)
    else $error("Command issued before the interface was ready");
  a_init_after_cal: assert property ($rose(init_done) |-> $past(phy_cal_done))
    else $error("Ready rose without calibration done");
  a_bcast_all_cs: assert property (mem_cmd_valid && wr_q && bc_q
      && st_q == drp_pkg::DRP_ST_ISSUE |-> mem_cs == '1)
    else $error("Broadcast write did not select every chip");
  a_pch_last_only: assert property (mem_cmd_valid && (mem_cmd == drp_pkg::DRP_CMD_RDA
      || mem_cmd == drp_pkg::DRP_CMD_WRA) |-> cl_q && left_q == `DRP_SIZE_W'(1))
    else $error("Auto-precharge on a beat that is not the last");
  a_pch_when_asked: assert property (mem_cmd_valid && st_q == drp_pkg::DRP_ST_ISSUE
      && cl_q && left_q == `DRP_SIZE_W'(1) |-> mem_cmd inside {drp_pkg::DRP_CMD_RDA,
      drp_pkg::DRP_CMD_WRA})
    else $error("Last beat of a close-row request lacks auto-precharge");
  a_ack_after_entry: assert property ($rose(sr_ack) |-> $past(mem_cmd_valid
      && mem_cmd_ready && mem_cmd == drp_pkg::DRP_CMD_SRE))
    else $error("Acknowledge rose without a self-refresh entry");
  a_sr_held: assert property (sr_ack && sr_req && st_q == drp_pkg::DRP_ST_SR_HLD
      |=> sr_ack && !(mem_cmd_valid && mem_cmd == drp_pkg::DRP_CMD_SRX))
    else $error("Self-refresh left while still requested");
  a_ack_after_exit: assert property ($fell(sr_ack) |-> $past(mem_cmd_valid
      && mem_cmd_ready && mem_cmd == drp_pkg::DRP_CMD_SRX))
    else $error("Acknowledge fell before exit completed");
  a_exit_starts: assert property (sr_ack && !sr_req && st_q == drp_pkg::DRP_ST_SR_HLD
      |=> mem_cmd_valid && mem_cmd == drp_pkg::DRP_CMD_SRX)
    else $error("Released self-refresh was not exited");

  c_sr_cycle: cover property ($rose(sr_ack) ##[1:50] $fell(sr_ack));
  c_bcast_wr: cover property (mem_cmd_valid && mem_cmd_ready && bc_q && wr_q);
  c_pch_burst: cover property (mem_cmd_valid && mem_cmd == drp_pkg::DRP_CMD_WRA
      && $past(left_q, 2) != `DRP_SIZE_W'(1));
  c_early_req: cover property ((req_read || req_write) && req_ready && !init_done);
endmodule

/* File: hw/drp_cfg.svh */
// Timing-free constants and field layouts of the DRAM local request port.
`ifndef DRP_CFG_SVH
`define DRP_CFG_SVH

// ------------------------------------------------------------
// Memory geometry and controller rate
// ------------------------------------------------------------
`define DRP_DQ_W        16
`define DRP_HALF_RATE   0
`define DRP_RATE_MUL    ((`DRP_HALF_RATE != 0) ? 4 : 2)
`define DRP_WDATA_W     (`DRP_DQ_W * `DRP_RATE_MUL)
`define DRP_BE_W        (`DRP_WDATA_W / 8)
`define DRP_CS_W        2
`define DRP_ADDR_W      24
`define DRP_SIZE_W      7

// ------------------------------------------------------------
// Options, queue depths and request entry layout
// ------------------------------------------------------------
`define DRP_AUTOPCH_EN  1'b1
`define DRP_REQ_DEPTH   8
`define DRP_DAT_DEPTH   4
`define DRP_E_WRITE     0
`define DRP_E_BCAST     1
`define DRP_E_CLOSE     2
`define DRP_E_SIZE_LO   3
`define DRP_E_ADDR_LO   (`DRP_E_SIZE_LO + `DRP_SIZE_W)
`define DRP_ENTRY_W     (`DRP_E_ADDR_LO + `DRP_ADDR_W)

`endif

/* File: hw/drp_pkg.sv */
// Types shared by the DRAM local request port.
package drp_pkg;

  // Commands handed to the memory-side sequencer.
  typedef enum logic [2:0] {
    DRP_CMD_RD  = 3'h0,
    DRP_CMD_WR  = 3'h1,
    DRP_CMD_RDA = 3'h2,
    DRP_CMD_WRA = 3'h3,
    DRP_CMD_SRE = 3'h4,
    DRP_CMD_SRX = 3'h5
  } drp_cmd_t;

  // Gray coded in listed order; DRP_ST_IDLE to DRP_ST_SR_IN and DRP_ST_SR_OUT back to DRP_ST_IDLE each flip two bits.
  typedef enum logic [2:0] {
    DRP_ST_INIT   = 3'b000,
    DRP_ST_IDLE   = 3'b001,
    DRP_ST_ISSUE  = 3'b011,
    DRP_ST_SR_IN  = 3'b010,
    DRP_ST_SR_HLD = 3'b110,
    DRP_ST_SR_OUT = 3'b111
  } drp_state_t;

endpackage

/* File: tb/drp_master_model.sv */
// Behavioural user-side master that raises requests and holds them until taken.
`timescale 1ns/1ps
`include "drp_cfg.svh"

module drp_master_model (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   go,
  input  wire logic                   go_wr,
  input  wire logic [`DRP_ADDR_W-1:0] go_addr,
  input  wire logic [`DRP_SIZE_W-1:0] go_size,
  input  wire logic                   go_bcast,
  input  wire logic                   go_close,
  input  wire logic                   req_ready,
  output logic                        req_read,
  output logic                        req_write,
  output logic [`DRP_ADDR_W-1:0]      req_addr,
  output logic [`DRP_SIZE_W-1:0]      req_size,
  output logic                        req_bcast,
  output logic                        req_close_row
);
  // A request stands until an edge sees req_ready high; after release the qualifiers
  // flip, so a controller that samples them late picks up wrong values.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {req_read, req_write, req_addr, req_size, req_bcast, req_close_row} <= '0;
    end else if (go) begin
      req_read      <= !go_wr;
      req_write     <= go_wr;
      req_addr      <= go_addr;
      req_size      <= go_size;
      req_bcast     <= go_bcast;
      req_close_row <= go_close;
    end else if ((req_read || req_write) && req_ready) begin
      req_read      <= 1'h0;
      req_write     <= 1'h0;
      req_addr      <= ~req_addr;
      req_size      <= ~req_size;
      req_bcast     <= ~req_bcast;
      req_close_row <= ~req_close_row;
    end
  end
endmodule

/* File: tb/drp_request_port_tb.sv */
// Self-checking testbench of the DRAM local request port.
`timescale 1ns/1ps
`include "drp_cfg.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end

module drp_request_port_tb;
  logic clk_sys, rst, req_read, req_write, req_bcast, req_close_row, req_ready;
  logic wr_valid, wr_ready, sr_req, sr_ack, phy_cal_done, init_done;
  logic mem_cmd_valid, mem_cmd_ready, go, go_wr, go_bcast, go_close;
  logic [`DRP_ADDR_W-1:0]  req_addr, mem_addr, go_addr;
  logic [`DRP_SIZE_W-1:0]  req_size, go_size;
  logic [`DRP_WDATA_W-1:0] wr_data, mem_wdata;
  logic [`DRP_BE_W-1:0]    wr_be, mem_be;
  logic [`DRP_CS_W-1:0]    mem_cs;
  drp_pkg::drp_cmd_t       mem_cmd;
  int                      miscompares = 0;
  int                      total_checks = 0;

  drp_request_port u_drp_request_port (.clk_sys(clk_sys), .rst(rst), .req_read(req_read),
    .req_write(req_write), .req_addr(req_addr), .req_size(req_size), .req_bcast(req_bcast),
    .req_close_row(req_close_row), .req_ready(req_ready), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_be(wr_be), .wr_ready(wr_ready), .sr_req(sr_req), .sr_ack(sr_ack),
    .phy_cal_done(phy_cal_done), .init_done(init_done), .mem_cmd_valid(mem_cmd_valid),
    .mem_cmd_ready(mem_cmd_ready), .mem_cmd(mem_cmd), .mem_cs(mem_cs), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be));

  drp_master_model u_drp_master_model (.clk_sys(clk_sys), .rst(rst), .go(go), .go_wr(go_wr),
    .go_addr(go_addr), .go_size(go_size), .go_bcast(go_bcast), .go_close(go_close),
    .req_ready(req_ready), .req_read(req_read), .req_write(req_write), .req_addr(req_addr),
    .req_size(req_size), .req_bcast(req_bcast), .req_close_row(req_close_row));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // The verdict is printed in this one place only.
  task automatic tally_and_finish();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic fail_wait();
    `CHK("wait", 1'h1, 1'h0);
    tally_and_finish();
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // Hands one request to the master model and waits until the port takes it.
  task automatic issue(input logic wr, input logic [23:0] a, input logic [6:0] s,
                       input logic b, input logic c);
    int i;
    {go, go_wr, go_addr, go_size, go_bcast, go_close} = {1'h1, wr, a, s, b, c};
    tick(1);
    go = 1'h0;
    for (i = 0; i < 200 && (req_read || req_write); i++) tick(1);
    if (i == 200) fail_wait();
  endtask

  // Waits for a command, stalls it for a while, then judges it and accepts it.
  task automatic get_cmd(input drp_pkg::drp_cmd_t c, input logic [1:0] cs,
                         input logic [23:0] a, input logic [31:0] wd, input bit full,
                         input int stall);
    int i;
    for (i = 0; i < 200 && !mem_cmd_valid; i++) tick(1);
    if (i == 200) fail_wait();
    tick(stall);
    `CHK("mem_cmd_valid", 1'h1, mem_cmd_valid);
    `CHK("mem_cmd", c, mem_cmd);
    if (full) begin
      `CHK("mem_cs", cs, mem_cs);
      `CHK("mem_addr", a, mem_addr);
      `CHK("mem_wdata", wd, mem_wdata);
      `CHK("mem_be", (c == drp_pkg::DRP_CMD_WR || c == drp_pkg::DRP_CMD_WRA) ? 4'hF : 4'h0,
           mem_be);
    end
    mem_cmd_ready = 1'h1;
    tick(1);
    mem_cmd_ready = 1'h0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // A write taken before calibration ends must wait; size zero counts as one beat.
  task automatic t_init();
    int i;
    `CHK("req_ready", 1'h1, req_ready);
    `CHK("wr_ready", 1'h1, wr_ready);
    {wr_valid, wr_data} = {1'h1, 32'hA5A5_0001};
    tick(1);
    wr_valid = 1'h0;
    issue(1'h1, 24'h80_0005, 7'h00, 1'h0, 1'h0);
    repeat (10) begin
      `CHK("early_valid", 1'h0, mem_cmd_valid);
      `CHK("early_init", 1'h0, init_done);
      tick(1);
    end
    phy_cal_done = 1'h1;
    for (i = 0; i < 3 && !init_done; i++) tick(1);
    `CHK("init_done", 1'h1, init_done);
    phy_cal_done = 1'h0;
    get_cmd(drp_pkg::DRP_CMD_WR, 2'h2, 24'h80_0005, 32'hA5A5_0001, 1, 0);
    `CHK("init_sticky", 1'h1, init_done);
  endtask

  // Fills the data buffer until it refuses, then spends it on broadcast and plain writes.
  task automatic t_data_path();
    int n;
    n = 0;
    wr_valid = 1'h1;
    for (int i = 0; i < 6 && wr_ready; i++) begin
      wr_data = 32'hD000_0000 + 32'(i);
      tick(1);
      n++;
    end
    wr_valid = 1'h0;
    `CHK("fifo_depth", `DRP_DAT_DEPTH, n);
    issue(1'h1, 24'h00_0010, 7'h02, 1'h1, 1'h1);
    issue(1'h0, 24'h80_0020, 7'h01, 1'h0, 1'h0);
    issue(1'h1, 24'h00_0030, 7'h02, 1'h0, 1'h0);
    issue(1'h0, 24'h00_0040, 7'h01, 1'h0, 1'h1);
    get_cmd(drp_pkg::DRP_CMD_WR, 2'h3, 24'h00_0010, 32'hD000_0000, 1, 2);
    get_cmd(drp_pkg::DRP_CMD_WRA, 2'h3, 24'h00_0011, 32'hD000_0001, 1, 0);
    get_cmd(drp_pkg::DRP_CMD_RD, 2'h2, 24'h80_0020, 32'h0000_0000, 1, 1);
    get_cmd(drp_pkg::DRP_CMD_WR, 2'h1, 24'h00_0030, 32'hD000_0002, 1, 0);
    get_cmd(drp_pkg::DRP_CMD_WR, 2'h1, 24'h00_0031, 32'hD000_0003, 1, 0);
    get_cmd(drp_pkg::DRP_CMD_RDA, 2'h1, 24'h00_0040, 32'h0000_0000, 1, 0);
    `CHK("fifo_empty", 1'h1, wr_ready);
  endtask

  // Stalls the memory side until the request queue refuses, then drains it in order.
  task automatic t_queue_full();
    int taken;
    taken = 0;
    for (int k = 0; k < 12 && req_ready; k++) begin
      issue(1'h0, 24'(k), 7'h01, 1'h0, 1'h0);
      taken++;
    end
    `CHK("queue_full", 1'h1, taken >= 8 && taken <= 9);
    {go, go_wr, go_addr, go_size, go_bcast, go_close} = {2'h2, 24'(taken), 7'h01, 2'h0};
    tick(1);
    go = 1'h0;
    tick(4);
    `CHK("refused", 2'h2, {req_read, req_ready});
    for (int k = 0; k <= taken; k++) begin
      get_cmd(drp_pkg::DRP_CMD_RD, 2'h1, 24'(k), 32'h0000_0000, 1, k % 2);
    end
  endtask

  // Enters self-refresh, holds it with a read waiting, then leaves with a slow exit.
  task automatic t_self_refresh();
    int i;
    sr_req = 1'h1;
    get_cmd(drp_pkg::DRP_CMD_SRE, 2'h0, 24'h00_0000, 32'h0000_0000, 0, 0);
    for (i = 0; i < 3 && !sr_ack; i++) tick(1);
    `CHK("sr_ack_rise", 1'h1, sr_ack);
    issue(1'h0, 24'h00_0050, 7'h01, 1'h0, 1'h0);
    repeat (20) begin
      `CHK("sr_hold_cmd", 1'h0, mem_cmd_valid);
      `CHK("sr_hold_ack", 1'h1, sr_ack);
      tick(1);
    end
    sr_req = 1'h0;
    tick(2);
    `CHK("sr_ack_exit", 1'h1, sr_ack);
    get_cmd(drp_pkg::DRP_CMD_SRX, 2'h0, 24'h00_0000, 32'h0000_0000, 0, 3);
    for (i = 0; i < 3 && sr_ack; i++) tick(1);
    `CHK("sr_ack_fall", 1'h0, sr_ack);
    get_cmd(drp_pkg::DRP_CMD_RD, 2'h1, 24'h00_0050, 32'h0000_0000, 1, 0);
  endtask

  // ------------------------------------------------------------
  // Clock, reset and main sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Inputs change one nanosecond after each rising edge so sampling never races.
  initial begin
    {rst, wr_valid, wr_data, wr_be} = {1'h1, 33'h0, 4'hF};
    {sr_req, phy_cal_done, mem_cmd_ready} = 3'h0;
    {go, go_wr, go_addr, go_size, go_bcast, go_close} = '0;
    tick(5);
    rst = 1'h0;
    t_init();
    t_data_path();
    t_queue_full();
    t_self_refresh();
    tally_and_finish();
  end
endmodule
